// ===== host_model.sv
// Host software model driving the register port and the sample strobe
`timescale 1ns/1ps
module host_model (
   // Clock
   input wire logic ref_clk_i,
   // Register port toward the block
   output left_adc_line_pkg::reg_req_t reg_req_o,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i,
   // Sample strobe
   output logic fs_tick_o
);
   initial begin
      reg_req_o = '0;
      fs_tick_o = 1'b0;
   end

   // Caller keeps codes 9..14 out and shared-input modes equal
   task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge ref_clk_i);
      reg_req_o.wr <= 1'b1;
      reg_req_o.addr <= addr;
      reg_req_o.wdata <= data;
      @(posedge ref_clk_i);
      reg_req_o.wr <= 1'b0;
      // Released lines show the inverse, not a kind stale copy
      reg_req_o.addr <= ~addr;
      reg_req_o.wdata <= ~data;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      @(posedge ref_clk_i);
      reg_req_o.rd <= 1'b1;
      reg_req_o.addr <= addr;
      @(posedge ref_clk_i);
      reg_req_o.rd <= 1'b0;
      reg_req_o.addr <= ~addr;
      #1;
      ok = reg_rvalid_i;
      data = reg_rdata_i;
   endtask : rd_reg

   // Sample strobes spaced a few clocks apart
   task automatic tick(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk_i);
         fs_tick_o <= 1'b1;
         @(posedge ref_clk_i);
         fs_tick_o <= 1'b0;
         repeat (3) @(posedge ref_clk_i);
      end
   endtask : tick
endmodule : host_model

// ===== left_adc_line_input_control.sv
// Left ADC line input routing registers with level decode and soft stepping
//
// Functional notes
// R1: First line D7 selects single-ended or differential.
// R2: Shared input needs equal mode in both channels.
// R3: Level code steps 1.5 dB, 0 to -12 dB.
// R4: Valid first line level connects to mixer.
// R5: First line level 1111 disconnects input.
// R6: Level codes 1001 to 1110 never written.
// R7: First line D2 powers left ADC up.
// R8: Step field 00 per sample, 01 every two.
// R9: Step field 10 or 11 applies gain directly.
// R10: Second line D7 selects single-ended or differential.
// R11: Second line level decodes alike, 1111 disconnects.
// R12: Second line D2 weakly biases unselected inputs.
// R13: Second line D1..D0 read zero, write zero.
// R14: Both registers reset to 0x78.
`timescale 1ns/1ps
module left_adc_line_input_control (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Register port from the control bus
   input wire left_adc_line_pkg::reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Sample rate strobe
   input wire logic fs_tick_i,
   // Analog control
   output left_adc_line_pkg::left_adc_ctrl_t ctrl_o,
   output logic level_settled_o
);

   localparam int N = left_adc_line_pkg::NUM_INPUTS;

   logic [7:0] line_one_ff;
   logic [7:0] line_two_ff;
   logic [7:0] nxt_line_one;
   logic [7:0] nxt_line_two;
   logic [7:0] rdata_ff;
   logic rvalid_ff;
   left_adc_line_pkg::left_adc_ctrl_t ctrl_ff;
   left_adc_line_pkg::left_adc_ctrl_t nxt_ctrl;
   logic settled_ff;

   wire logic hit_one;
   wire logic hit_two;
   wire logic wr_one;
   wire logic wr_two;
   wire logic [7:0] rd_sel;
   wire left_adc_line_pkg::step_mode_t step_mode;
   wire logic [3:0] level_code [N];
   wire logic [3:0] target [N];
   wire logic [3:0] applied [N];
   wire logic connect [N];
   wire logic all_settled;

   // Address decode
   assign hit_one = (reg_req_i.addr == left_adc_line_pkg::ADDR_LINE_ONE);
   assign hit_two = (reg_req_i.addr == left_adc_line_pkg::ADDR_LINE_TWO);
   assign wr_one = reg_req_i.wr && hit_one;
   assign wr_two = reg_req_i.wr && hit_two;

   // Low bits of the second register are not storable
   assign nxt_line_one = wr_one ? reg_req_i.wdata : line_one_ff;
   assign nxt_line_two = wr_two ? (reg_req_i.wdata & left_adc_line_pkg::LINE_TWO_WMASK)
      : line_two_ff; // [R13]

   assign rd_sel = hit_one ? line_one_ff
      : hit_two ? line_two_ff
      : left_adc_line_pkg::UNMAPPED_RDATA;

   // Field extraction
   assign level_code[0] = line_one_ff[left_adc_line_pkg::LEVEL_MSB:left_adc_line_pkg::LEVEL_LSB];
   assign level_code[1] = line_two_ff[left_adc_line_pkg::LEVEL_MSB:left_adc_line_pkg::LEVEL_LSB];
   assign step_mode = left_adc_line_pkg::step_mode_t'(
      line_one_ff[left_adc_line_pkg::STEP_MSB:left_adc_line_pkg::STEP_LSB]);

   // One decoder and one ramp per line input
   generate
      for (genvar i = 0; i < N; i++) begin : g_input
         line_level_decode u_decode (
            .code_i(level_code[i]),
            .connect_o(connect[i]),
            .target_o(target[i])
         ); // [R4] [R5] [R11]
         soft_step_ramp u_ramp (
            .ref_clk_i(ref_clk_i),
            .rst_n_i(rst_n_i),
            .fs_tick_i(fs_tick_i),
            .step_mode_i(step_mode),
            .connect_i(connect[i]),
            .target_i(target[i]),
            .level_o(applied[i])
         ); // [R8] [R9]
      end
   endgenerate

   assign all_settled = (applied[0] == target[0]) && (applied[1] == target[1]);

   // Output assembly; software keeps a shared input's mode consistent [R2]
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_ctrl.first_line_left_input_mode = line_one_ff[left_adc_line_pkg::MODE_BIT]; // [R1]
      nxt_ctrl.second_line_left_input_mode = line_two_ff[left_adc_line_pkg::MODE_BIT]; // [R10]
      nxt_ctrl.first_line_left_input_connect = connect[0]; // [R4] [R5]
      nxt_ctrl.second_line_left_input_connect = connect[1]; // [R11]
      nxt_ctrl.adc_power_up = line_one_ff[left_adc_line_pkg::POWER_BIT]; // [R7]
      nxt_ctrl.weak_bias_en = line_two_ff[left_adc_line_pkg::BIAS_BIT]; // [R12]
      nxt_ctrl.first_atten_half_db = left_adc_line_pkg::level_half_db(applied[0]); // [R3]
      nxt_ctrl.second_atten_half_db = left_adc_line_pkg::level_half_db(applied[1]); // [R3]
      nxt_ctrl.step_rate = step_mode;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         line_one_ff <= left_adc_line_pkg::LINE_ONE_RESET; // [R14]
         line_two_ff <= left_adc_line_pkg::LINE_TWO_RESET; // [R14]
      end else begin
         line_one_ff <= nxt_line_one;
         line_two_ff <= nxt_line_two;
      end
   end

   // Read data holds until the next read
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_ff <= left_adc_line_pkg::RDATA_RESET;
         rvalid_ff <= 1'b0;
      end else begin
         rdata_ff <= reg_req_i.rd ? rd_sel : rdata_ff;
         rvalid_ff <= reg_req_i.rd;
      end
   end

   // Reset image matches the register reset: both inputs off, max attenuation
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_ff <= '{first_line_left_input_mode: 1'b0, second_line_left_input_mode: 1'b0,
            first_line_left_input_connect: 1'b0, second_line_left_input_connect: 1'b0,
            adc_power_up: 1'b0, weak_bias_en: 1'b0,
            first_atten_half_db: left_adc_line_pkg::HALF_DB_MAX,
            second_atten_half_db: left_adc_line_pkg::HALF_DB_MAX,
            step_rate: 2'h0};
         settled_ff <= 1'b1;
      end else begin
         ctrl_ff <= nxt_ctrl;
         settled_ff <= all_settled;
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign reg_rvalid_o = rvalid_ff;
   assign ctrl_o = ctrl_ff;
   assign level_settled_o = settled_ff;

   // Helper: no register written since reset
   logic untouched_ff;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         untouched_ff <= 1'b1;
      end else if (reg_req_i.wr && (hit_one || hit_two)) begin
         untouched_ff <= 1'b0;
      end
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_write_one;
      reg_req_i.wr && hit_one;
   endsequence

   sequence s_write_two;
      reg_req_i.wr && hit_two;
   endsequence

   sequence s_hold_step_fs;
      (step_mode == left_adc_line_pkg::STEP_EVERY_FS) && connect[0] && !fs_tick_i
         ##1 (step_mode == left_adc_line_pkg::STEP_EVERY_FS) && connect[0];
   endsequence

   a_first_mode_follow: // [R1]
      assert property (s_write_one |-> ##2
         ctrl_o.first_line_left_input_mode == $past(reg_req_i.wdata[7], 2))
      else $error("first input mode does not follow write");

   a_first_level_connect: // [R4]
      assert property (s_write_one ##0 (reg_req_i.wdata[6:3] <= 4'h8) |-> ##2
         ctrl_o.first_line_left_input_connect)
      else $error("valid level did not connect first input");

   a_first_level_off: // [R5]
      assert property (s_write_one ##0 (reg_req_i.wdata[6:3] == 4'hF) |-> ##2
         !ctrl_o.first_line_left_input_connect)
      else $error("level 1111 did not disconnect first input");

   a_atten_scale: // [R3]
      assert property (applied[0] == 4'h8 |=> ctrl_o.first_atten_half_db == 5'h18)
      else $error("code 1000 is not -12 dB");

   a_adc_power_bit: // [R7]
      assert property (s_write_one |-> ##2 ctrl_o.adc_power_up == $past(reg_req_i.wdata[2], 2))
      else $error("power control does not follow write");

   a_step_hold_fs: // [R8]
      assert property (s_hold_step_fs |-> $stable(applied[0]))
      else $error("level moved without a sample strobe");

   a_step_up_fs: // [R8]
      assert property ((step_mode == left_adc_line_pkg::STEP_EVERY_FS) && fs_tick_i
         && connect[0] && (applied[0] < target[0]) && !wr_one |=>
         applied[0] == $past(applied[0]) + 4'h1)
      else $error("level did not step on sample strobe");

   a_step_off_jump: // [R9]
      assert property (step_mode[1] && connect[0] && !wr_one |=> applied[0] == target[0])
      else $error("disabled stepping did not apply level at once");

   a_second_mode_follow: // [R10]
      assert property (s_write_two |-> ##2
         ctrl_o.second_line_left_input_mode == $past(reg_req_i.wdata[7], 2))
      else $error("second input mode does not follow write");

   a_second_level_off: // [R11]
      assert property (s_write_two ##0 (reg_req_i.wdata[6:3] == 4'hF) |-> ##2
         !ctrl_o.second_line_left_input_connect)
      else $error("level 1111 did not disconnect second input");

   a_weak_bias_bit: // [R12]
      assert property (s_write_two |-> ##2 ctrl_o.weak_bias_en == $past(reg_req_i.wdata[2], 2))
      else $error("weak bias does not follow write");

   a_reserved_zero: // [R13]
      assert property (reg_req_i.rd && hit_two |=> reg_rvalid_o && (reg_rdata_o[1:0] == 2'h0))
      else $error("reserved bits read nonzero");

   a_reset_value: // [R14]
      assert property (untouched_ff && reg_req_i.rd && (hit_one || hit_two) |=>
         reg_rdata_o == 8'h78)
      else $error("register not at reset value");

   sequence s_hold_step_two;
      (step_mode == left_adc_line_pkg::STEP_EVERY_TWO_FS) && connect[0] && !fs_tick_i
         ##1 (step_mode == left_adc_line_pkg::STEP_EVERY_TWO_FS) && connect[0];
   endsequence

   a_step_hold_two: // [R8]
      assert property (s_hold_step_two |-> $stable(applied[0]))
      else $error("level moved between sample strobes");

   a_step_down_fs: // [R8]
      assert property ((step_mode == left_adc_line_pkg::STEP_EVERY_FS) && fs_tick_i
         && connect[0] && (applied[0] > target[0]) && !wr_one |=>
         applied[0] == $past(applied[0]) - 4'h1)
      else $error("level did not step down on sample strobe");

   a_step_rate_follow: // [R8]
      assert property (s_write_one |-> ##2 ctrl_o.step_rate == $past(reg_req_i.wdata[1:0], 2))
      else $error("step rate does not follow write");

   // Second input ramps on the same strobe and step field
   a_second_step_up: // [R8]
      assert property ((step_mode == left_adc_line_pkg::STEP_EVERY_FS) && fs_tick_i
         && connect[1] && (applied[1] < target[1]) && !wr_two |=>
         applied[1] == $past(applied[1]) + 4'h1)
      else $error("second level did not step on sample strobe");

   a_second_step_off: // [R9]
      assert property (step_mode[1] && connect[1] && !wr_two |=> applied[1] == target[1])
      else $error("disabled stepping did not apply second level at once");

   a_second_level_connect: // [R11]
      assert property (s_write_two ##0 (reg_req_i.wdata[6:3] <= 4'h8) |-> ##2
         ctrl_o.second_line_left_input_connect)
      else $error("valid level did not connect second input");

   // Parking at the deepest step keeps a reconnect from jumping to full gain
   a_first_park: // [R5]
      assert property (!connect[0] |=> applied[0] == 4'h8)
      else $error("disconnected first input not parked");

   a_second_park: // [R11]
      assert property (!connect[1] |=> applied[1] == 4'h8)
      else $error("disconnected second input not parked");

   // Three half-decibel units per code over the whole table, not only its end
   a_first_atten_map: // [R3]
      assert property (1'b1 |=> ctrl_o.first_atten_half_db == 5'($past(applied[0])) * 5'h03)
      else $error("first attenuation is not three half steps per code");

   a_second_atten_map: // [R3]
      assert property (1'b1 |=> ctrl_o.second_atten_half_db == 5'($past(applied[1])) * 5'h03)
      else $error("second attenuation is not three half steps per code");

   // Masked on write, so a stray one from software never reaches the read path
   a_reserved_store: // [R13]
      assert property (line_two_ff[1:0] == 2'h0)
      else $error("reserved bits stored nonzero");

endmodule : left_adc_line_input_control

// ===== left_adc_line_pkg.sv
// Package with register map, field layout and carrier types of the left ADC line input block
package left_adc_line_pkg;

   // Page 0 register offsets
   localparam logic [7:0] ADDR_LINE_ONE = 8'h13;
   localparam logic [7:0] ADDR_LINE_TWO = 8'h14;

   // Values after reset and for unmapped reads
   localparam logic [7:0] LINE_ONE_RESET = 8'h78;
   localparam logic [7:0] LINE_TWO_RESET = 8'h78;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

   // Field positions
   localparam int MODE_BIT = 7;
   localparam int LEVEL_MSB = 6;
   localparam int LEVEL_LSB = 3;
   localparam int POWER_BIT = 2;
   localparam int BIAS_BIT = 2;
   localparam int STEP_MSB = 1;
   localparam int STEP_LSB = 0;

   // Second register low bits are read-only zero
   localparam logic [7:0] LINE_TWO_WMASK = 8'hFC;

   // Level codes
   localparam logic [3:0] LEVEL_ZERO_DB = 4'h0;
   localparam logic [3:0] LEVEL_MAX_ATTEN = 4'h8;
   localparam logic [3:0] LEVEL_DISCONNECT = 4'hF;
   localparam logic [3:0] LEVEL_ONE_STEP = 4'h1;
   localparam logic [4:0] HALF_DB_MAX = 5'h18;

   // Number of line inputs in this bank
   localparam int NUM_INPUTS = 2;

   typedef enum logic [1:0] {
      STEP_EVERY_FS = 2'b00,
      STEP_EVERY_TWO_FS = 2'b01,
      STEP_OFF_A = 2'b10,
      STEP_OFF_B = 2'b11
   } step_mode_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic first_line_left_input_mode;
      logic second_line_left_input_mode;
      logic first_line_left_input_connect;
      logic second_line_left_input_connect;
      logic adc_power_up;
      logic weak_bias_en;
      logic [4:0] first_atten_half_db;
      logic [4:0] second_atten_half_db;
      logic [1:0] step_rate;
   } left_adc_ctrl_t;

   // Attenuation in 0.5 dB units: code times three
   function automatic logic [4:0] level_half_db(input logic [3:0] code);
      level_half_db = {1'b0, code} + {code, 1'b0};
   endfunction : level_half_db

endpackage : left_adc_line_pkg

// ===== line_level_decode.sv
// Decoder from a four-bit line level code to mixer connect and target level
`timescale 1ns/1ps
module line_level_decode (
   // Level field
   input wire logic [3:0] code_i,
   // Decoded
   output logic connect_o,
   output logic [3:0] target_o
);

   // Reserved codes are kept off the mixer, same as disconnect
   wire logic code_valid;

   assign code_valid = (code_i <= left_adc_line_pkg::LEVEL_MAX_ATTEN); // [R4] [R5]
   assign connect_o = code_valid;
   assign target_o = code_valid ? code_i : left_adc_line_pkg::LEVEL_MAX_ATTEN; // [R3]

endmodule : line_level_decode

// ===== soft_step_ramp.sv
// Soft-stepping ramp of one input's applied attenuation toward its target
`timescale 1ns/1ps
module soft_step_ramp (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Sample strobe and settings
   input wire logic fs_tick_i,
   input wire left_adc_line_pkg::step_mode_t step_mode_i,
   input wire logic connect_i,
   input wire logic [3:0] target_i,
   // Applied level
   output logic [3:0] level_o
);

   logic [3:0] level_ff;
   logic [3:0] nxt_level;
   logic phase_ff;
   wire logic step_now;
   wire logic step_off;

   // Every second sample uses the toggle phase
   assign step_now = fs_tick_i
      && ((step_mode_i == left_adc_line_pkg::STEP_EVERY_FS)
      || ((step_mode_i == left_adc_line_pkg::STEP_EVERY_TWO_FS) && phase_ff)); // [R8]
   assign step_off = step_mode_i[1]; // [R9]

   // Disconnected input parks at most attenuation so reconnect ramps up softly
   always_comb begin
      nxt_level = level_ff;
      if (!connect_i) begin
         nxt_level = left_adc_line_pkg::LEVEL_MAX_ATTEN;
      end else if (step_off) begin
         nxt_level = target_i; // [R9]
      end else if (step_now && (level_ff < target_i)) begin
         nxt_level = level_ff + left_adc_line_pkg::LEVEL_ONE_STEP; // [R8]
      end else if (step_now && (level_ff > target_i)) begin
         nxt_level = level_ff - left_adc_line_pkg::LEVEL_ONE_STEP; // [R8]
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_ff <= left_adc_line_pkg::LEVEL_MAX_ATTEN;
         phase_ff <= 1'b0;
      end else begin
         level_ff <= nxt_level;
         phase_ff <= fs_tick_i ? ~phase_ff : phase_ff;
      end
   end

   assign level_o = level_ff;

endmodule : soft_step_ramp

// ===== tb.sv
// Testbench for the left ADC line input control registers
`timescale 1ns/1ps
module tb;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   left_adc_line_pkg::reg_req_t reg_req;
   logic [7:0] rdata;
   logic rvalid;
   logic fs_tick;
   left_adc_line_pkg::left_adc_ctrl_t ctrl;
   logic settled;
   int bad_count = 0;
   int n_tests = 0;
   logic [7:0] rd_val;
   logic rd_ok;

   always #12.5 ref_clk_i = ~ref_clk_i;

   host_model i_host (
      .ref_clk_i(ref_clk_i),
      .reg_req_o(reg_req),
      .reg_rdata_i(rdata),
      .reg_rvalid_i(rvalid),
      .fs_tick_o(fs_tick)
   );

   left_adc_line_input_control i_dut (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .reg_req_i(reg_req),
      .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid),
      .fs_tick_i(fs_tick),
      .ctrl_o(ctrl),
      .level_settled_o(settled)
   );

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      i_host.rd_reg(addr, rd_val, rd_ok);
      chk(32'(rd_ok), 32'h1);
      chk(32'(rd_val), 32'(exp));
   endtask : rd_chk

   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : wait_clk

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #400000;
      bad_count++;
      tally_and_finish();
   end

   initial begin
      repeat (16) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rd_chk(8'h13, 8'h78);
      rd_chk(8'h14, 8'h78);
      chk(32'(ctrl), 32'({6'h00, 5'h18, 5'h18, 2'h0}));
      // Differential, 0 dB, powered, stepping off
      i_host.wr_reg(8'h13, 8'h86);
      wait_clk(14);
      chk(32'(ctrl), 32'({6'h2A, 5'h00, 5'h18, 2'h2}));
      chk(32'(settled), 32'h1);
      // Whole gain table, each code one step from the last
      for (int c = 0; c <= 8; c++) begin
         i_host.wr_reg(8'h13, {1'h0, 4'(c), 3'h7});
         wait_clk(14);
         chk(32'(ctrl.first_atten_half_db), 32'(c * 3));
         chk(32'(ctrl.first_line_left_input_connect), 32'h1);
      end
      i_host.wr_reg(8'h13, 8'h7F);
      wait_clk(14);
      chk(32'(ctrl), 32'({6'h02, 5'h18, 5'h18, 2'h3}));
      // Ones in the read-only pair are dropped
      i_host.wr_reg(8'h14, 8'h97);
      rd_chk(8'h14, 8'h94);
      wait_clk(14);
      chk(32'(ctrl), 32'({6'h17, 5'h18, 5'h06, 2'h3}));
      i_host.wr_reg(8'h14, 8'h78);
      wait_clk(14);
      chk(32'(ctrl), 32'({6'h02, 5'h18, 5'h18, 2'h3}));
      // Unmapped places store nothing and answer reads with 0x00
      i_host.wr_reg(8'h12, 8'h00);
      rd_chk(8'h13, 8'h7F);
      rd_chk(8'h15, 8'h00);
      // Once per sample: no ticks, no motion; four ticks, four steps
      i_host.wr_reg(8'h13, 8'h04);
      wait_clk(20);
      chk(32'(ctrl.first_atten_half_db), 32'h18);
      i_host.tick(4);
      wait_clk(3);
      chk(32'(ctrl.first_atten_half_db), 32'h0C);
      // Every second sample: four ticks hold two steps whatever the phase
      i_host.wr_reg(8'h13, 8'h7D);
      wait_clk(4);
      i_host.wr_reg(8'h13, 8'h05);
      wait_clk(4);
      i_host.tick(4);
      wait_clk(3);
      chk(32'(ctrl.first_atten_half_db), 32'h12);
      chk(32'(settled), 32'h0);
      tally_and_finish();
   end
endmodule : tb
